// *** pso_sync.sv ***
// Two-flop synchroniser for a group of pin inputs.
// Assumes the pins change slowly against clock; a multi-bit group must be stable around each use.
`timescale 1ns/1ps
module pso_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // pso_sync

// *** pso_top.sv ***
// Constants, types and the top level of the sample output control of an 8-bit sampling converter.
// Assumes the converter clock pin runs well below half of clock, so each of its edges is seen.
// Every pin is a level input from outside this clock domain and passes two flops before use.
package pso_pkg;
  // Output code width and the width of each analog bus as it reaches the pins
  localparam int CODE_W = 8;
  localparam int ANA_W = 10;
  localparam logic [CODE_W-1:0] CODE_ZERO = 8'h00;
  localparam logic [CODE_W-1:0] CODE_FULL = 8'hFF;
  localparam int CLK_PERIOD_PS = 5000;
  // Output valid delay after the rising edge, least figure, in picoseconds
  localparam int OUTPUT_VALID_DELAY_PS = 5900;
  localparam int OD_CYC_RAW = (OUTPUT_VALID_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int OD_CYC = (OD_CYC_RAW < 1) ? 1 : OD_CYC_RAW;
  // Delay down counter: idle at zero, the word is released in the cycle it reads one
  localparam int OD_CNT_W = 3;
  localparam logic [OD_CNT_W-1:0] OD_LOAD = OD_CNT_W'(OD_CYC);
  localparam logic [OD_CNT_W-1:0] OD_IDLE = 3'h0;
  localparam logic [OD_CNT_W-1:0] OD_LAST = 3'h1;
  // Two and a half cycles from the falling edge: the word is driven on the third rising edge
  localparam int LAT_RISES = 3;
  localparam int STAGES = LAT_RISES - 1;

  // One result: its code and the side it saturated to, if any
  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic below;
    logic above;
  } pso_word_t;

  localparam pso_word_t WORD_RST = '{code: 8'h00, below: 1'b0, above: 1'b0};

  // Control pins, synchronised as one group
  typedef struct packed {
    logic sample_clk;
    logic power_down;
  } pso_ctl_t;

  // Input level and both ladder ends, synchronised as one group
  typedef struct packed {
    logic [ANA_W-1:0] level;
    logic [ANA_W-1:0] bottom;
    logic [ANA_W-1:0] top;
  } pso_analog_t;

  // Synchroniser widths of the two groups
  localparam int ANALOG_W = 3 * ANA_W;
  localparam int CTL_W = 2;
endpackage

`timescale 1ns/1ps
module pso_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic sample_clock_pin,
  input wire logic power_down_pin,
  input wire logic [pso_pkg::ANA_W-1:0] analog_level,
  input wire logic [pso_pkg::ANA_W-1:0] reference_bottom_level,
  input wire logic [pso_pkg::ANA_W-1:0] reference_top_level,
  output logic [pso_pkg::CODE_W-1:0] data_word,
  output logic data_below,
  output logic data_above,
  output logic data_strobe,
  output logic low_power
);
  // Quantise against the reference ladder; a collapsed ladder still saturates cleanly
  function automatic pso_pkg::pso_word_t pso_quantize(pso_pkg::pso_analog_t a);
    logic [pso_pkg::ANA_W-1:0] span;
    logic [pso_pkg::ANA_W-1:0] ofs;
    logic [pso_pkg::ANA_W+pso_pkg::CODE_W-1:0] num;
    logic [pso_pkg::ANA_W+pso_pkg::CODE_W-1:0] quo;
    pso_pkg::pso_word_t w;
    span = a.top - a.bottom;
    ofs = a.level - a.bottom;
    num = {ofs, pso_pkg::CODE_ZERO};
    quo = '0;
    w = pso_pkg::WORD_RST;
    if (a.level < a.bottom) begin
      w.code = pso_pkg::CODE_ZERO;
      w.below = 1'b1;
    end else if (a.level >= a.top) begin
      w.code = pso_pkg::CODE_FULL;
      w.above = 1'b1;
    end else begin
      // A full divider costs area but keeps every ladder span exact
      quo = num / {{pso_pkg::CODE_W{1'b0}}, span};
      w.code = quo[pso_pkg::CODE_W-1:0];
    end
    return w;
  endfunction

  pso_pkg::pso_ctl_t ctl_raw;
  pso_pkg::pso_ctl_t ctl_s;
  pso_pkg::pso_analog_t ana_raw;
  pso_pkg::pso_analog_t ana_s;

  assign ctl_raw = '{sample_clk: sample_clock_pin, power_down: power_down_pin};
  assign ana_raw = '{level: analog_level, bottom: reference_bottom_level, top: reference_top_level};

  // Control and analog pass the same two flops, so the captured level lines up with the edge
  pso_sync #(
    .W(pso_pkg::CTL_W)
  ) u_ctl_sync (
    .clock(clock),
    .rst(rst),
    .d(ctl_raw),
    .q(ctl_s)
  );

  pso_sync #(
    .W(pso_pkg::ANALOG_W)
  ) u_ana_sync (
    .clock(clock),
    .rst(rst),
    .d(ana_raw),
    .q(ana_s)
  );

  logic sclk_prev_q;
  logic pd_q;
  pso_pkg::pso_word_t cap_q;
  pso_pkg::pso_word_t stage_q [pso_pkg::STAGES];
  pso_pkg::pso_word_t pend_q;
  pso_pkg::pso_word_t out_q;
  logic [pso_pkg::OD_CNT_W-1:0] od_cnt_q;
  logic strobe_q;

  wire fall_seen = sclk_prev_q & ~ctl_s.sample_clk;
  wire rise_seen = ~sclk_prev_q & ctl_s.sample_clk;
  // Power-down freezes capture and the stage shifts, not the output delay; a halted clock simply gives no edges
  // Nothing is flushed on release, so the first words after power-down are stale samples
  wire active = ~ctl_s.power_down;
  wire do_capture = fall_seen & active;
  wire do_shift = rise_seen & active;
  wire od_done = (od_cnt_q == pso_pkg::OD_LAST);
  wire pso_pkg::pso_word_t sample_now = pso_quantize(ana_s);

  // The edge register resets to the idle pin level, so no false edge follows reset
  always_ff @(posedge clock) begin
    if (rst) begin
      sclk_prev_q <= 1'b0;
      pd_q <= 1'b0;
    end else begin
      sclk_prev_q <= ctl_s.sample_clk;
      pd_q <= ctl_s.power_down;
    end
  end

  pso_pkg::pso_word_t cap_d;
  assign cap_d = do_capture ? sample_now : cap_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      cap_q <= pso_pkg::WORD_RST;
    end else begin
      cap_q <= cap_d;
    end
  end

  // Two rising edges inside the pipeline, the third moves the word towards the pins
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < pso_pkg::STAGES; i++) begin
        stage_q[i] <= pso_pkg::WORD_RST;
      end
    end else if (do_shift) begin
      stage_q[0] <= cap_q;
      for (int i = 1; i < pso_pkg::STAGES; i++) begin
        stage_q[i] <= stage_q[i-1];
      end
    end
  end

  // Next values kept as named wires so the clocked blocks stay plain registers
  logic od_busy;
  logic [pso_pkg::OD_CNT_W-1:0] od_cnt_d;
  pso_pkg::pso_word_t pend_d;
  pso_pkg::pso_word_t out_d;

  assign od_busy = (od_cnt_q != pso_pkg::OD_IDLE);
  // The output delay is counted after the rising edge; an edge seen before power-down still lands
  assign od_cnt_d = do_shift ? pso_pkg::OD_LOAD : (od_busy ? od_cnt_q - pso_pkg::OD_LAST : od_cnt_q);
  assign pend_d = do_shift ? stage_q[pso_pkg::STAGES-1] : pend_q;
  // The word outputs change only on a finished delay, so power-down and a stopped clock hold them
  assign out_d = od_done ? pend_q : out_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      pend_q <= pso_pkg::WORD_RST;
      od_cnt_q <= pso_pkg::OD_IDLE;
    end else begin
      pend_q <= pend_d;
      od_cnt_q <= od_cnt_d;
    end
  end

  // The strobe marks the cycle in which the new word first stands
  always_ff @(posedge clock) begin
    if (rst) begin
      out_q <= pso_pkg::WORD_RST;
      strobe_q <= 1'b0;
    end else begin
      out_q <= out_d;
      strobe_q <= od_done;
    end
  end

  assign data_word = out_q.code;
  assign data_below = out_q.below;
  assign data_above = out_q.above;
  assign data_strobe = strobe_q;
  assign low_power = pd_q;
endmodule // pso_top

// *** pso_top_props.sv ***
// Port checker for pso_top.
// Assumes converter clock phases of 8 clocks.
`timescale 1ns/1ps
module pso_top_props (
  input logic clock,
  input logic rst,
  input logic sample_clock_pin,
  input logic power_down_pin,
  input logic [7:0] data_word,
  input logic data_below,
  input logic data_above,
  input logic data_strobe,
  input logic low_power
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_strobe_due: assert property ($changed(data_word) |-> data_strobe) else $error("strobe");
  a_below_zero: assert property (data_below |-> data_word == 8'h00) else $error("below");
  a_above_full: assert property (data_above |-> data_word == 8'hFF) else $error("above");
  a_pd_on: assert property ($rose(power_down_pin) |-> ##[1:4] low_power) else $error("pd on");
  a_pd_off: assert property ($fell(power_down_pin) |-> ##[1:4] !low_power) else $error("pd off");
  a_pd_frozen: assert property (low_power [*6] |-> !data_strobe) else $error("pd");
  a_stop_held: assert property ($stable(sample_clock_pin) [*8] |-> $stable(data_word)) else $error("stop");
  a_rise_phase: assert property (data_strobe |-> sample_clock_pin) else $error("phase");
endmodule // pso_top_props
bind pso_top pso_top_props u_props (.*);

// *** pso_rx_model.sv ***
// Receiving logic: converter clock, power-down pin, word latch.
// Assumes run and pd_req change at the falling clock edge.
`timescale 1ns/1ps
module pso_rx_model (
  input logic clock,
  input logic run,
  input logic pd_req,
  input logic [7:0] data_word,
  input logic data_strobe,
  output logic sample_clock_pin = 1'b0,
  output logic power_down_pin = 1'b0,
  output logic [7:0] last_word = 8'h00
);
  logic [2:0] cnt = 3'h0;
  // About one microsecond of 5 ns cycles after power-down release or a clock restart
  localparam int SETTLE_CYC = 200;
  int settle = 0;
  // Clock stands still while run is low
  always @(negedge clock) begin
    power_down_pin <= pd_req;
    cnt <= cnt + {2'h0, run};
    if (run && cnt == 3'h7) sample_clock_pin <= !sample_clock_pin;
    if (pd_req || !run) settle <= SETTLE_CYC;
    else if (settle != 0) settle <= settle - 1;
  end
  // Words seen in power-down or while the converter settles are not trusted
  always @(posedge clock) if (data_strobe && !power_down_pin && settle == 0) last_word <= data_word;
endmodule // pso_rx_model

// *** pso_top_tb_top.sv ***
// Bench for pso_top: codes, latency, power-down, stopped clock.
// Assumes pso_rx_model drives the converter pins.
`timescale 1ns/1ps
module pso_top_tb_top;
  logic clock = 1'b0, rst = 1'b1, run = 1'b0, pd_req = 1'b0;
  logic [9:0] lvl = 10'h000, bot = 10'h064, top = 10'h164;
  logic sample_clock_pin, power_down_pin, data_below, data_above, data_strobe, low_power;
  logic [7:0] data_word, last_word;
  wire [9:0] outw = {data_word, data_below, data_above};
  int failures = 0, cmp_count = 0, r;
  initial forever #2.5 clock = !clock;
  pso_top DUT (.analog_level(lvl), .reference_bottom_level(bot), .reference_top_level(top), .*);
  pso_rx_model rx (.*);
  task automatic wrap_up(input int hung);
    failures += hung;
    $display("%0d checks, %0d errors", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: %h not %h", $time, got, exp);
    end
  endtask
  // Bounded wait for a word, counting converter clock rises in r
  task automatic wait_word(input logic [7:0] w);
    logic p;
    r = 0;
    for (int i = 0; i < 300 && data_word !== w; i++) begin
      p = sample_clock_pin;
      @(negedge clock);
      r += int'(sample_clock_pin & !p);
    end
    if (data_word !== w) wrap_up(1);
  endtask
  task automatic conv(input logic [9:0] l, input logic [9:0] e);
    lvl = l;
    wait_word(e[9:2]);
    chk(outw, e);
  endtask
  task automatic t_codes();
    conv(10'h163, {8'hFF, 2'h0});
    conv(10'h032, {8'h00, 2'h2});
    conv(10'h164, {8'hFF, 2'h1});
    conv(10'h064, {8'h00, 2'h0});
    bot = 10'h000;
    top = 10'h200;
    conv(10'h12C, {8'h96, 2'h0});
  endtask
  // A level set just after a fall is captured at the next fall
  task automatic t_latency();
    logic p;
    p = 1'b0;
    for (int i = 0; i < 40 && !(p && !sample_clock_pin); i++) begin
      p = sample_clock_pin;
      @(negedge clock);
    end
    if (!(p && !sample_clock_pin)) wrap_up(1);
    lvl = 10'h0C8;
    wait_word(8'h64);
    chk(10'(r), 10'h004);
  endtask
  task automatic t_freeze();
    conv(10'h0FE, {8'h7F, 2'h0});
    pd_req <= 1'b1;
    repeat (10) @(negedge clock);
    lvl = 10'h3FF;
    repeat (100) @(negedge clock);
    chk({data_word, 1'b0, low_power}, {8'h7F, 2'h1});
    pd_req <= 1'b0;
    run <= 1'b0;
    repeat (100) @(negedge clock);
    chk({last_word, 1'b0, low_power}, {8'h7F, 2'h0});
    chk(outw, {8'h7F, 2'h0});
    run <= 1'b1;
    conv(10'h3FF, {8'hFF, 2'h1});
    repeat (50) @(negedge clock);
    chk({last_word, 2'h0}, {8'h7F, 2'h0});
    repeat (150) @(negedge clock);
    chk({last_word, 2'h0}, {8'hFF, 2'h0});
  endtask
  initial begin
    repeat (4) @(negedge clock);
    rst = 1'b0;
    run <= 1'b1;
    t_codes();
    t_latency();
    t_freeze();
    wrap_up(0);
  end
endmodule // pso_top_tb_top
